// ===== inc/seg_drv_pkg.sv
package seg_drv_pkg;
  // ****************************************************
  // frame layout
  // ****************************************************
  localparam int FRAME_BITS = 35;
  localparam int CHAIN_BITS = FRAME_BITS + 1;
  localparam int START_POS  = CHAIN_BITS - 1;
  localparam int BUF_DEPTH  = 2;
  localparam logic [FRAME_BITS-1:0] SEG_RESET  = 35'h0;
  localparam logic [CHAIN_BITS-1:0] CHAIN_CLEAR = 36'h0;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_CLEAR = 2'b10
  } link_state_t;
endpackage

// ===== inc/frame_if.sv
`timescale 1ns/1ns
interface frame_if #(
  parameter int WIDTH = 35
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ===== src/frame_buffer.sv
`timescale 1ns/1ns
module frame_buffer #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 2
) (
  input  wire logic clk,
  input  wire logic reset_n,
  frame_if.snk      wr,
  frame_if.src      rd
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + PW'(1);
  endfunction

  assign wr.ready = (count_r != FULL_CNT);
  assign rd.valid = (count_r != '0);
  assign rd.data  = mem_r[rd_ptr_r];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // ****************************************************
  // storage
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (push) begin
      mem_r[wr_ptr_r] <= wr.data;
    end
  end

  // ****************************************************
  // pointers and fill level
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= bump(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + (PW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (PW+1)'(1);
      end
    end
  end
endmodule

// ===== src/serial_led_segment_driver.sv
`timescale 1ns/1ns
// Overview of operation
// - a frame is a start bit of one followed by 35 data bits, no load line.
// - frame end is found from the start bit alone, using data and clock.
// - on the 36th clock rise all 35 bits are captured, then loaded to latches through the buffer when latch_hold is low.
// - in the low phase after the strobe every shift stage is cleared.
// - the clear spares the first stage input so frames run back to back.
// - power-up reset clears all shift stages and all output latches.
// - after reset a start bit on the first clock resumes reception.
// - the first bit after the start bit drives segment output zero.
// - a latched one switches its segment on, a zero leaves it off.
// - latches hold between transfers and change only on new values.
// - the enable variant drops the 35th output for a data-enable input.
// - outputs update only after the 36th bit is fully clocked in.
module serial_led_segment_driver #(
  parameter bit HAS_DATA_EN = 1'b0,
  parameter int FRAME_BITS  = seg_drv_pkg::FRAME_BITS,
  parameter int BUF_DEPTH   = seg_drv_pkg::BUF_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  ser_clk,
  input  wire logic                  ser_data,
  input  wire logic                  data_en,
  input  wire logic                  latch_hold,
  output logic [FRAME_BITS-1:0]      seg_on,
  output logic                       frame_busy,
  output logic                       buf_full
);
  localparam int CHAIN_BITS = FRAME_BITS + 1;

  logic                  ser_clk_r;
  logic [CHAIN_BITS-1:0] chain_r;
  logic [CHAIN_BITS-1:0] chain_nxt;
  logic [FRAME_BITS-1:0] seg_r;
  logic                  busy_r;
  logic                  full_r;
  logic                  clear_pend_r;
  logic                  rise;
  logic                  fall;
  logic                  enabled;
  logic                  take;
  logic                  done;
  logic                  strobe_r;
  logic [FRAME_BITS-1:0] frame_r;
  seg_drv_pkg::link_state_t state_r;

  frame_if #(.WIDTH(FRAME_BITS)) push_if ();
  frame_if #(.WIDTH(FRAME_BITS)) pop_if ();

  // ****************************************************
  // bit ordering and masking
  // ****************************************************
  // first arrival goes to output zero
  function automatic logic [FRAME_BITS-1:0] order_bits(
    input logic [CHAIN_BITS-1:0] c
  );
    for (int i = 0; i < FRAME_BITS; i++) begin
      order_bits[i] = c[FRAME_BITS-1-i];
    end
  endfunction

  // variant keeps its last output dark
  function automatic logic [FRAME_BITS-1:0] shown(
    input logic [FRAME_BITS-1:0] d
  );
    shown = d;
    if (HAS_DATA_EN) begin
      shown[FRAME_BITS-1] = 1'b0;
    end
  endfunction

  // ****************************************************
  // serial clock edges
  // ****************************************************
  assign rise      = ser_clk && !ser_clk_r;
  assign fall      = !ser_clk && ser_clk_r;
  assign enabled   = HAS_DATA_EN ? data_en : 1'b1;
  assign take      = rise && enabled && push_if.ready;
  assign chain_nxt = {chain_r[CHAIN_BITS-2:0], ser_data};
  // start bit reaching the top ends a frame
  assign done      = take && chain_nxt[CHAIN_BITS-1];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_clk_r <= 1'b0;
    end else begin
      ser_clk_r <= ser_clk;
    end
  end

  // ****************************************************
  // shift chain
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_r <= seg_drv_pkg::CHAIN_CLEAR;
    end else if (take) begin
      chain_r <= chain_nxt;
    end else if (fall && clear_pend_r) begin
      chain_r <= seg_drv_pkg::CHAIN_CLEAR;
    end
  end

  // ****************************************************
  // clear request after a transfer
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_pend_r <= 1'b0;
    end else if (done) begin
      clear_pend_r <= 1'b1;
    end else if (fall) begin
      clear_pend_r <= 1'b0;
    end
  end

  // ****************************************************
  // transfer strobe and frame capture
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= done;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_r <= seg_drv_pkg::SEG_RESET;
    end else if (done) begin
      frame_r <= order_bits(chain_nxt);
    end
  end

  // ****************************************************
  // link state
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= seg_drv_pkg::LINK_IDLE;
    end else begin
      case (state_r)
        seg_drv_pkg::LINK_IDLE: begin
          if (take && ser_data) begin
            state_r <= seg_drv_pkg::LINK_SHIFT;
          end
        end
        seg_drv_pkg::LINK_SHIFT: begin
          if (done) begin
            state_r <= seg_drv_pkg::LINK_CLEAR;
          end
        end
        seg_drv_pkg::LINK_CLEAR: begin
          if (fall) begin
            state_r <= seg_drv_pkg::LINK_IDLE;
          end
        end
        default: state_r <= seg_drv_pkg::LINK_IDLE;
      endcase
    end
  end

  // ****************************************************
  // frame buffer
  // ****************************************************
  assign push_if.data  = frame_r;
  assign push_if.valid = strobe_r;
  assign pop_if.ready  = !latch_hold;

  frame_buffer #(
    .WIDTH (FRAME_BITS),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk     (clk),
    .reset_n (reset_n),
    .wr      (push_if),
    .rd      (pop_if)
  );

  // ****************************************************
  // output latches
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_r <= seg_drv_pkg::SEG_RESET;
    end else if (pop_if.valid && pop_if.ready) begin
      seg_r <= shown(pop_if.data);
    end
  end

  // ****************************************************
  // frame activity
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_r != seg_drv_pkg::LINK_IDLE);
    end
  end

  // ****************************************************
  // buffer level
  // ****************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      full_r <= 1'b0;
    end else begin
      full_r <= !push_if.ready;
    end
  end

  assign seg_on     = seg_r;
  assign frame_busy = busy_r;
  assign buf_full   = full_r;
endmodule

// ===== sim/seg_src.sv
`timescale 1ns/1ns
module seg_src (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end
  // ****
  // frame: start bit, then bit zero first
  // ****
  task automatic send(input logic [34:0] bits, input int half);
    logic [35:0] f;
    f = {bits, 1'b1};
    for (int i = 0; i < 36; i++) begin
      ser_data <= f[i];
      repeat (half) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (half) @(posedge clk);
      ser_clk <= 1'b0;
    end
    ser_data <= ~f[35];
    repeat (half) @(posedge clk);
  endtask
  // ****
  // single clock pulse outside a frame
  // ****
  task automatic pulse(input logic d, input int half);
    ser_data <= d;
    repeat (half) @(posedge clk);
    ser_clk <= 1'b1;
    repeat (half) @(posedge clk);
    ser_clk <= 1'b0;
    repeat (half) @(posedge clk);
  endtask
endmodule

// ===== sim/serial_led_segment_driver_asserts.sv
`timescale 1ns/1ns
module serial_led_segment_driver_asserts #(
  parameter int FRAME_BITS = 35
) (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  ser_clk,
  input wire logic                  ser_data,
  input wire logic                  data_en,
  input wire logic                  latch_hold,
  input wire logic [FRAME_BITS-1:0] seg_on,
  input wire logic                  frame_busy,
  input wire logic                  buf_full
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_RST_CLEAR: assert property ($rose(reset_n) |-> seg_on == '0)
    else $error("segments not clear after reset");
  AST_HOLD: assert property (latch_hold [*3] |-> $stable(seg_on))
    else $error("segments moved while held");
  AST_START: assert property ($rose(ser_clk) && ser_data && !frame_busy
    && !buf_full && data_en |-> ##2 frame_busy)
    else $error("start bit not taken");
  AST_ZERO: assert property ($rose(ser_clk) && !ser_data && !frame_busy
    |-> ##2 !frame_busy) else $error("zero taken as start");
  AST_REFUSE: assert property ($rose(ser_clk) && buf_full && !frame_busy
    && latch_hold && $past(latch_hold) |-> ##2 !frame_busy)
    else $error("rise taken while full");
  AST_DRAIN: assert property (!latch_hold [*4] |-> !buf_full)
    else $error("buffer stays full");
  AST_END: assert property ($fell(frame_busy) |-> !$past(ser_clk))
    else $error("frame ended with clock high");
  AST_BUSY_HIGH: assert property (frame_busy && ser_clk |=> frame_busy)
    else $error("frame ended during clock high");
endmodule
bind serial_led_segment_driver serial_led_segment_driver_asserts #(
  .FRAME_BITS(FRAME_BITS)
) u_chk (.clk(clk), .reset_n(reset_n), .ser_clk(ser_clk),
  .ser_data(ser_data), .data_en(data_en), .latch_hold(latch_hold),
  .seg_on(seg_on),
  .frame_busy(frame_busy), .buf_full(buf_full));

// ===== sim/serial_led_segment_driver_bench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  num_errors++; $display("CHECK FAILED at %0t: mismatch", $time); end end
module serial_led_segment_driver_bench;
  logic        clk;
  logic        reset_n;
  logic        data_en;
  logic        latch_hold;
  logic        ser_clk;
  logic        ser_data;
  logic [34:0] seg_on;
  logic        frame_busy;
  logic        buf_full;
  logic [34:0] seg_on_en;
  logic        frame_busy_en;
  logic        buf_full_en;
  int          num_errors;
  int          comparisons;
  seg_src u_src (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data));
  serial_led_segment_driver u_dut (.clk(clk), .reset_n(reset_n),
    .ser_clk(ser_clk), .ser_data(ser_data), .data_en(data_en),
    .latch_hold(latch_hold), .seg_on(seg_on), .frame_busy(frame_busy),
    .buf_full(buf_full));
  serial_led_segment_driver #(.HAS_DATA_EN(1'b1)) u_dut_en (.clk(clk),
    .reset_n(reset_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .data_en(data_en), .latch_hold(latch_hold), .seg_on(seg_on_en),
    .frame_busy(frame_busy_en), .buf_full(buf_full_en));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // ****
  // scenarios
  // ****
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_frame(input logic [34:0] p, input int half);
    @(posedge clk);
    u_src.send(p, half);
    repeat (4) @(posedge clk);
    #1 `CHK(seg_on, p)
    `CHK(seg_on_en, p & 35'h3_ffff_ffff)
  endtask
  task automatic t_hold();
    @(posedge clk);
    latch_hold <= 1'b1;
    u_src.send(35'h2_1234_5678, 2);
    u_src.send(35'h4_8765_4321, 2);
    #1 `CHK(buf_full, 1'b1)
    `CHK(buf_full_en, 1'b1)
    `CHK(seg_on, 35'h0_0000_0001)
    @(posedge clk);
    u_src.send(35'h1_1111_1111, 2);
    latch_hold <= 1'b0;
    repeat (8) @(posedge clk);
    #1 `CHK(seg_on, 35'h4_8765_4321)
    `CHK(buf_full, 1'b0)
  endtask
  task automatic t_enable();
    @(posedge clk);
    data_en <= 1'b0;
    u_src.send(35'h2_aaaa_5555, 2);
    repeat (4) @(posedge clk);
    #1 `CHK(seg_on, 35'h2_aaaa_5555)
    `CHK(seg_on_en, 35'h0_8765_4321)
    `CHK(frame_busy_en, 1'b0)
    @(posedge clk);
    data_en <= 1'b1;
    t_frame(35'h4_0000_00ff, 2);
  endtask
  task automatic t_idle_zero();
    @(posedge clk);
    u_src.pulse(1'b0, 2);
    #1 `CHK(frame_busy, 1'b0)
    t_frame(35'h3_0f0f_0f0f, 2);
  endtask
  initial begin
    num_errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    data_en = 1'b1;
    latch_hold = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    #1 `CHK(seg_on, 35'h0)
    `CHK(frame_busy, 1'b0)
    t_frame(35'h5_a5a5_a5a5, 250);
    t_frame(35'h7_ffff_ffff, 2);
    t_frame(35'h0_0000_0001, 2);
    t_hold();
    t_enable();
    t_idle_zero();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule
